// ---- hw/stw_top.sv ----
`include "stw_regs.svh"
module stw_top
	import stw_pkg::*;
(
	input  wire logic          mclk_in,
	input  wire logic          sys_rst_in,
	input  wire logic          clk_en_in,
	input  wire logic [7:0]    sfr_addr_in,
	input  wire logic          sfr_wr_in,
	input  wire logic          sfr_rd_in,
	input  stw_pkg::stw_byte_type sfr_wdata_in,
	input  wire logic          watchdog_irq_enable_in,
	input  wire logic          watchdog_event_clr_in,
	output stw_pkg::stw_byte_type sfr_rdata_out,
	output logic               micro_tick_out,
	output logic               milli_tick_out,
	output logic               hundred_tick_out,
	output logic               slow_pending_out,
	output logic               fast_pending_out,
	output logic               watchdog_event_out,
	output logic               watchdog_irq_out,
	output logic               watchdog_irq_high_out,
	output logic               watchdog_counting_out,
	output logic               pulse_module_gate_out,
	output logic               converter_gate_out,
	output logic               serial_periph_gate_out
);
	// ----------------------------------------
	// register storage
	// ----------------------------------------
	logic [4:0] gate_q;
	logic [4:0] prio_q;
	logic [4:0] micro_div_q;
	logic [7:0] mlow_q;
	logic [7:0] mhigh_q;
	logic [7:0] hund_div_q;
	logic [4:0] wd_count_q;
	logic [2:0] wd_bits_q;
	logic       slow_pend_q;
	logic       fast_pend_q;
	logic       wd_en_q;
	logic       wd_evt_q;
	logic [5:0] wd_cnt_q;
	logic [4:0] micro_cnt_q;
	logic [15:0] milli_cnt_q;
	logic [7:0] hund_cnt_q;
	logic       micro_tick_q;
	logic       milli_tick_q;
	logic       hund_tick_q;
	logic       wd_irq_q;
	stw_byte_type rdata_q;

	logic wr_gate;
	logic wr_prio;
	logic wr_slow;
	logic wr_fast;
	logic wr_wdog;
	logic rd_slow;
	logic rd_fast;
	logic time_run;
	logic wd_run;
	logic micro_tick;
	logic milli_tick;
	logic hund_tick;
	logic slow_exp;
	logic fast_exp;
	logic [6:0] slow_cnt;
	logic [6:0] fast_cnt;
	logic arm_fire;
	logic disarm_fire;
	logic restart_fire;
	logic wd_expire;

	assign wr_gate = sfr_wr_in && (sfr_addr_in == `STW_ADDR_GATE);
	assign wr_prio = sfr_wr_in && (sfr_addr_in == `STW_ADDR_PRIO);
	assign wr_slow = sfr_wr_in && (sfr_addr_in == `STW_ADDR_SLOW);
	assign wr_fast = sfr_wr_in && (sfr_addr_in == `STW_ADDR_FAST);
	assign wr_wdog = sfr_wr_in && (sfr_addr_in == `STW_ADDR_WDOG);
	assign rd_slow = sfr_rd_in && (sfr_addr_in == `STW_ADDR_SLOW);
	assign rd_fast = sfr_rd_in && (sfr_addr_in == `STW_ADDR_FAST);

	assign time_run = !gate_q[`STW_BIT_GTIME];
	assign wd_run   = !gate_q[`STW_BIT_GWDOG];

	// ----------------------------------------
	// register writes
	// ----------------------------------------
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			gate_q      <= 5'(`STW_RST_GATE);
			prio_q      <= 5'(`STW_RST_PRIO);
			micro_div_q <= `STW_RST_MICRO;
			mlow_q      <= `STW_RST_MLOW;
			mhigh_q     <= `STW_RST_MHIGH;
			hund_div_q  <= `STW_RST_HUND;
			wd_count_q  <= 5'(`STW_RST_WDOG);
			wd_bits_q   <= 3'h0;
		end else if (clk_en_in && sfr_wr_in) begin
			unique case (sfr_addr_in)
				`STW_ADDR_GATE:  gate_q      <= sfr_wdata_in[4:0];
				`STW_ADDR_PRIO:  prio_q      <= sfr_wdata_in[4:0];
				`STW_ADDR_MICRO: micro_div_q <= sfr_wdata_in[4:0];
				`STW_ADDR_MLOW:  mlow_q      <= sfr_wdata_in;
				`STW_ADDR_MHIGH: mhigh_q     <= sfr_wdata_in;
				`STW_ADDR_HUND:  hund_div_q  <= sfr_wdata_in;
				`STW_ADDR_WDOG: begin
					wd_count_q <= sfr_wdata_in[4:0];
					wd_bits_q  <= sfr_wdata_in[7:5];
				end
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------
	// prescaler
	// ----------------------------------------
	// micro, milli and hundred-milli tick decode
	assign micro_tick = time_run && (micro_cnt_q == micro_div_q);
	assign milli_tick = time_run && (milli_cnt_q == {mhigh_q, mlow_q});
	assign hund_tick  = milli_tick && (hund_cnt_q == hund_div_q);

	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			micro_cnt_q <= 5'h00;
			milli_cnt_q <= 16'h0000;
			hund_cnt_q  <= 8'h00;
		end else if (clk_en_in && time_run) begin
			// a lowered divisor below the count wraps once via >=
			micro_cnt_q <= (micro_cnt_q >= micro_div_q) ? 5'h00
				: micro_cnt_q + 5'h01;
			milli_cnt_q <= (milli_cnt_q >= {mhigh_q, mlow_q}) ? 16'h0000
				: milli_cnt_q + 16'h0001;
			if (milli_tick) begin
				hund_cnt_q <= (hund_cnt_q >= hund_div_q) ? 8'h00
					: hund_cnt_q + 8'h01;
			end
		end
	end

	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			micro_tick_q <= 1'b0;
			milli_tick_q <= 1'b0;
			hund_tick_q  <= 1'b0;
		end else if (clk_en_in) begin
			micro_tick_q <= micro_tick;
			milli_tick_q <= milli_tick;
			hund_tick_q  <= hund_tick;
		end
	end

	// ----------------------------------------
	// interval timers
	// ----------------------------------------
	// slow interval
	stw_interval u_slow (
		.mclk_in        (mclk_in),
		.sys_rst_in     (sys_rst_in),
		.clk_en_in      (clk_en_in),
		.reset_count_in (`STW_RST_SLOW),
		.tick_in        (hund_tick),
		.wr_in          (wr_slow),
		.wdata_in       (sfr_wdata_in),
		.count_out      (slow_cnt),
		.expire_out     (slow_exp)
	);

	stw_interval u_fast (
		.mclk_in        (mclk_in),
		.sys_rst_in     (sys_rst_in),
		.clk_en_in      (clk_en_in),
		.reset_count_in (`STW_RST_FAST),
		.tick_in        (milli_tick),
		.wr_in          (wr_fast),
		.wdata_in       (sfr_wdata_in),
		.count_out      (fast_cnt),
		.expire_out     (fast_exp)
	);

	// set beats the read clear so no expiry is lost
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			slow_pend_q <= 1'b0;
			fast_pend_q <= 1'b0;
		end else if (clk_en_in) begin
			if (slow_exp) begin
				slow_pend_q <= 1'b1;
			end else if (rd_slow) begin
				slow_pend_q <= 1'b0;
			end
			if (fast_exp) begin
				fast_pend_q <= 1'b1;
			end else if (rd_fast) begin
				fast_pend_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// watchdog
	// ----------------------------------------
	// arm sequence
	stw_seq u_arm (
		.mclk_in    (mclk_in),
		.sys_rst_in (sys_rst_in),
		.clk_en_in  (clk_en_in),
		.wr_in      (wr_wdog),
		.bit_in     (sfr_wdata_in[`STW_BIT_ARM]),
		.fire_out   (arm_fire)
	);

	stw_seq u_disarm (
		.mclk_in    (mclk_in),
		.sys_rst_in (sys_rst_in),
		.clk_en_in  (clk_en_in),
		.wr_in      (wr_wdog),
		.bit_in     (sfr_wdata_in[`STW_BIT_DISARM]),
		.fire_out   (disarm_fire)
	);

	stw_seq u_restart (
		.mclk_in    (mclk_in),
		.sys_rst_in (sys_rst_in),
		.clk_en_in  (clk_en_in),
		.wr_in      (wr_wdog),
		.bit_in     (sfr_wdata_in[`STW_BIT_RESTART]),
		.fire_out   (restart_fire)
	);

	// expiry window
	// expiry on tick count+2 after restart: the first tick is partial,
	// so the window is count+1 to count+2 full periods
	// limitation: a count lowered below the running value waits for a wrap
	assign wd_expire = wd_en_q && wd_run && hund_tick
		&& (wd_cnt_q == ({1'b0, wd_count_q} + 6'h01));

	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			wd_en_q  <= 1'b0;
			wd_cnt_q <= 6'h00;
		end else if (clk_en_in) begin
			if (disarm_fire) begin
				wd_en_q <= 1'b0;
			end else if (arm_fire) begin
				wd_en_q <= 1'b1;
			end
			// restart re-counts from zero; the first tick lands anywhere
			if (restart_fire || arm_fire || !wd_en_q) begin
				wd_cnt_q <= 6'h00;
			end else if (wd_run && hund_tick && !wd_expire) begin
				wd_cnt_q <= wd_cnt_q + 6'h01;
			end else if (wd_expire) begin
				wd_cnt_q <= 6'h00;
			end
		end
	end

	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			wd_evt_q <= 1'b0;
			wd_irq_q <= 1'b0;
		end else if (clk_en_in) begin
			if (wd_expire) begin
				wd_evt_q <= 1'b1;
			end else if (watchdog_event_clr_in) begin
				wd_evt_q <= 1'b0;
			end
			wd_irq_q <= (wd_evt_q || wd_expire) && watchdog_irq_enable_in;
		end
	end

	// ----------------------------------------
	// read data
	// ----------------------------------------
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			rdata_q <= 8'h00;
		end else if (clk_en_in) begin
			unique case (sfr_addr_in)
				`STW_ADDR_GATE:  rdata_q <= {3'h0, gate_q};
				`STW_ADDR_PRIO:  rdata_q <= {3'h7, prio_q};
				`STW_ADDR_SLOW:  rdata_q <= {1'b0, slow_cnt};
				`STW_ADDR_FAST:  rdata_q <= {1'b0, fast_cnt};
				`STW_ADDR_MICRO: rdata_q <= {3'h0, micro_div_q};
				`STW_ADDR_MLOW:  rdata_q <= mlow_q;
				`STW_ADDR_MHIGH: rdata_q <= mhigh_q;
				`STW_ADDR_HUND:  rdata_q <= hund_div_q;
				`STW_ADDR_WDOG:  rdata_q <= {wd_bits_q, wd_count_q};
				default:         rdata_q <= 8'h00;
			endcase
		end
	end

	assign sfr_rdata_out          = rdata_q;
	assign micro_tick_out         = micro_tick_q;
	assign milli_tick_out         = milli_tick_q;
	assign hundred_tick_out       = hund_tick_q;
	assign slow_pending_out       = slow_pend_q;
	assign fast_pending_out       = fast_pend_q;
	assign watchdog_event_out     = wd_evt_q;
	assign watchdog_irq_out       = wd_irq_q;
	assign watchdog_irq_high_out  = prio_q[`STW_BIT_WPRIO];
	assign watchdog_counting_out  = wd_en_q;
	assign pulse_module_gate_out  = gate_q[4];
	assign converter_gate_out     = gate_q[3];
	assign serial_periph_gate_out = gate_q[0];
endmodule

// ---- hw/stw_regs.svh ----
`ifndef STW_REGS_SVH
`define STW_REGS_SVH
// Contract
// - micro tick every (micro divider field + 1) clocks; field resets to 03h.
// - milli tick every (high*256 + low + 1) clocks from the divider pair.
// - hundred-milli tick every (hundred divider + 1) milli ticks; resets 63h.
// - milli tick feeds flash erase timing, micro tick flash write timing.
// - slow timer raises pending every (count + 1) hundred-milli ticks.
// - reading slow timer register clears its pending; status shows it.
// - slow reload select reads 0; 0 loads at expiry, 1 loads at once.
// - fast timer raises pending every (count + 1) milli ticks; resets 7Fh.
// - reading fast timer register clears fast pending.
// - fast reload select reads 0; 0 delays reload, 1 reloads at once.
// - arm bit written 1 then 0 sets watchdog counting enable.
// - disarm bit written 1 then 0 clears watchdog counting enable.
// - restart bit written 1 then 0 restarts the watchdog counter.
// - watchdog expires after count+1 to count+2 hundred-milli ticks.
// - power gating bits power down modules; register resets to 1Fh.
// - watchdog priority bit 4 selects high (1) or low (0) priority.
// - watchdog request passes only while its enable bit is 1.

// ----------------------------------------
// register addresses
// ----------------------------------------
`define STW_ADDR_GATE   8'hF1
`define STW_ADDR_PRIO   8'hF8
`define STW_ADDR_SLOW   8'hF9
`define STW_ADDR_FAST   8'hFA
`define STW_ADDR_MICRO  8'hFB
`define STW_ADDR_MLOW   8'hFC
`define STW_ADDR_MHIGH  8'hFD
`define STW_ADDR_HUND   8'hFE
`define STW_ADDR_WDOG   8'hFF

// ----------------------------------------
// reset values
// ----------------------------------------
`define STW_RST_GATE    8'h1F
`define STW_RST_PRIO    8'hE0
`define STW_RST_SLOW    7'h7F
`define STW_RST_FAST    7'h7F
`define STW_RST_MICRO   5'h03
`define STW_RST_MLOW    8'h9F
`define STW_RST_MHIGH   8'h0F
`define STW_RST_HUND    8'h63
`define STW_RST_WDOG    8'h00

// ----------------------------------------
// field positions
// ----------------------------------------
`define STW_BIT_RELOAD  7
`define STW_BIT_ARM     7
`define STW_BIT_DISARM  6
`define STW_BIT_RESTART 5
`define STW_BIT_WPRIO   4
`define STW_BIT_GWDOG   2
`define STW_BIT_GTIME   1
`endif

// ---- hw/stw_pkg.sv ----
package stw_pkg;
	typedef logic [7:0] stw_byte_type;
	typedef enum logic [1:0] {
		STW_SEQ_IDLE,
		STW_SEQ_SEEN_ONE
	} stw_seq_type;
endpackage

// ---- hw/stw_interval.sv ----
`include "stw_regs.svh"
// interval counter with delayed or immediate reload
module stw_interval
	import stw_pkg::*;
(
	input  wire logic       mclk_in,
	input  wire logic       sys_rst_in,
	input  wire logic       clk_en_in,
	input  wire logic [6:0] reset_count_in,
	input  wire logic       tick_in,
	input  wire logic       wr_in,
	input  wire logic [7:0] wdata_in,
	output logic      [6:0] count_out,
	output logic            expire_out
);
	logic [6:0] reload_q;
	logic [6:0] cnt_q;

	assign count_out  = reload_q;
	assign expire_out = tick_in && (cnt_q == 7'h00);

	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			reload_q <= reset_count_in;
			cnt_q    <= reset_count_in;
		end else if (clk_en_in) begin
			// a delayed write only moves reload_q; the next expiry takes it
			if (wr_in) begin
				reload_q <= wdata_in[6:0];
			end
			// immediate reload
			if (wr_in && wdata_in[`STW_BIT_RELOAD]) begin
				cnt_q <= wdata_in[6:0];
			end else if (tick_in) begin
				if (cnt_q == 7'h00) begin
					cnt_q <= reload_q;
				end else begin
					cnt_q <= cnt_q - 7'h01;
				end
			end
		end
	end
endmodule

// ---- hw/stw_seq.sv ----
// detects a write of 1 followed by a write of 0 on one control bit
module stw_seq
	import stw_pkg::*;
(
	input  wire logic mclk_in,
	input  wire logic sys_rst_in,
	input  wire logic clk_en_in,
	input  wire logic wr_in,
	input  wire logic bit_in,
	output logic      fire_out
);
	stw_seq_type state_q;

	assign fire_out = wr_in && !bit_in && (state_q == STW_SEQ_SEEN_ONE);

	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			state_q <= STW_SEQ_IDLE;
		end else if (clk_en_in && wr_in) begin
			unique case (state_q)
				STW_SEQ_IDLE: begin
					state_q <= bit_in ? STW_SEQ_SEEN_ONE : STW_SEQ_IDLE;
				end
				STW_SEQ_SEEN_ONE: begin
					state_q <= bit_in ? STW_SEQ_SEEN_ONE : STW_SEQ_IDLE;
				end
				default: begin
					state_q <= STW_SEQ_IDLE;
				end
			endcase
		end
	end
endmodule

// ---- dv/stw_core_model.sv ----
// ----------------------------------------
// core software on the register bus
// ----------------------------------------
module stw_core_model
	import stw_pkg::*;
(
	input  wire logic             mclk_in,
	input  stw_pkg::stw_byte_type sfr_rdata_in,
	output logic [7:0]            sfr_addr_out,
	output logic                  sfr_wr_out,
	output logic                  sfr_rd_out,
	output stw_pkg::stw_byte_type sfr_wdata_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic aux_flag_q;
	initial begin
		sfr_addr_out = 8'h00;
		sfr_wr_out = 1'b0;
		sfr_rd_out = 1'b0;
		sfr_wdata_out = 8'h00;
		aux_flag_q = 1'b1;
	end
	// released data shows the inverse, not a stale copy
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk_in);
		sfr_addr_out <= a;
		sfr_wdata_out <= d;
		sfr_wr_out <= 1'b1;
		@(posedge mclk_in);
		sfr_wr_out <= 1'b0;
		sfr_wdata_out <= ~d;
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge mclk_in);
		sfr_addr_out <= a;
		sfr_rd_out <= 1'b1;
		@(posedge mclk_in);
		sfr_rd_out <= 1'b0;
		#1;
		d = sfr_rdata_in;
	endtask
	task automatic pulse_bit(input int b, input logic [4:0] cnt);
		wr_reg(8'hFF, (8'h01 << b) | {3'h0, cnt});
		wr_reg(8'hFF, {3'h0, cnt});
	endtask
	task automatic ack_fast(output logic [7:0] d);
		rd_reg(8'hFA, d);
		aux_flag_q = 1'b0;
	endtask
endmodule

// ---- dv/stw_top_asserts.sv ----
// ----------------------------------------
// port checks of the timebase block
// ----------------------------------------
module stw_top_asserts
	import stw_pkg::*;
(
	input  wire logic             mclk_in,
	input  wire logic             sys_rst_in,
	input  wire logic             clk_en_in,
	input  wire logic [7:0]       sfr_addr_in,
	input  wire logic             sfr_wr_in,
	input  wire logic             sfr_rd_in,
	input  stw_pkg::stw_byte_type sfr_wdata_in,
	input  wire logic             watchdog_irq_enable_in,
	input  wire logic             watchdog_event_clr_in,
	input  stw_pkg::stw_byte_type sfr_rdata_out,
	input  wire logic             milli_tick_out,
	input  wire logic             hundred_tick_out,
	input  wire logic             slow_pending_out,
	input  wire logic             fast_pending_out,
	input  wire logic             watchdog_event_out,
	input  wire logic             watchdog_irq_out,
	input  wire logic             watchdog_irq_high_out,
	input  wire logic             watchdog_counting_out,
	input  wire logic             pulse_module_gate_out,
	input  wire logic             converter_gate_out,
	input  wire logic             serial_periph_gate_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (sys_rst_in);
	logic wr_ff;
	logic rd_ok;
	assign wr_ff = sfr_wr_in && clk_en_in && sfr_addr_in == 8'hFF;
	assign rd_ok = sfr_rd_in && clk_en_in;
	sequence arm_one;
		wr_ff && sfr_wdata_in[7];
	endsequence
	sequence arm_zero;
		wr_ff && !sfr_wdata_in[7];
	endsequence
	sequence off_one;
		wr_ff && sfr_wdata_in[6];
	endsequence
	sequence off_zero;
		wr_ff && !sfr_wdata_in[6];
	endsequence
	arm_sets_a: assert property (arm_one ##[1:3] arm_zero |=>
		watchdog_counting_out) else $error("arm sequence missed");
	disarm_clears_a: assert property (off_one ##[1:3] off_zero |=>
		!watchdog_counting_out) else $error("disarm sequence missed");
	fast_read_clr_a: assert property (rd_ok && sfr_addr_in == 8'hFA
		|=> !fast_pending_out || milli_tick_out)
		else $error("fast pending not cleared");
	slow_read_clr_a: assert property (rd_ok && sfr_addr_in == 8'hF9
		|=> !slow_pending_out || hundred_tick_out)
		else $error("slow pending not cleared");
	reload_reads_zero_a: assert property (clk_en_in &&
		(sfr_addr_in == 8'hF9 || sfr_addr_in == 8'hFA)
		|=> !sfr_rdata_out[7]) else $error("reload bit read as one");
	gate_bits_follow_a: assert property (sfr_wr_in && clk_en_in &&
		sfr_addr_in == 8'hF1 |=> {pulse_module_gate_out,
		converter_gate_out, serial_periph_gate_out} ==
		{$past(sfr_wdata_in[4]), $past(sfr_wdata_in[3]),
		$past(sfr_wdata_in[0])}) else $error("gate outputs wrong");
	prio_bit_follow_a: assert property (sfr_wr_in && clk_en_in &&
		sfr_addr_in == 8'hF8 |=> watchdog_irq_high_out ==
		$past(sfr_wdata_in[4])) else $error("priority output wrong");
	irq_masked_a: assert property (!watchdog_irq_enable_in &&
		clk_en_in |=> !watchdog_irq_out) else $error("masked irq passed");
	irq_passes_a: assert property (watchdog_irq_enable_in &&
		watchdog_event_out && clk_en_in |=> watchdog_irq_out)
		else $error("irq lost");
	event_sticky_a: assert property (watchdog_event_out &&
		!watchdog_event_clr_in |=> watchdog_event_out)
		else $error("event flag dropped");
	milli_pulse_a: assert property (milli_tick_out && clk_en_in |=>
		!milli_tick_out) else $error("milli tick too long");
endmodule
bind stw_top stw_top_asserts u_asrt (.*);

// ---- dv/system_timebase_watchdog_tb.sv ----
// ----------------------------------------
// self-checking bench of the timebase block
// ----------------------------------------
module system_timebase_watchdog_tb
	import stw_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic         mclk_in;
	logic         sys_rst_in;
	logic         clk_en_in;
	logic         irq_en;
	logic         evt_clr;
	logic [7:0]   addr;
	logic         wr;
	logic         rd;
	stw_byte_type wdata;
	stw_byte_type rdata;
	logic         micro, milli, hund, slow_p, fast_p;
	logic         evt, irq, irq_hi, cnt_on, pg, cg, sg;
	int           mismatches, check_count, cyc, last_t;
	wire [5:0]    mon = {evt, slow_p, fast_p, hund, milli, micro};
	logic [7:0]   ra [10] = '{8'hF0, 8'hF1, 8'hF8, 8'hF9, 8'hFA,
		8'hFB, 8'hFC, 8'hFD, 8'hFE, 8'hFF};
	logic [7:0]   rv [10] = '{8'h00, 8'h1F, 8'hE0, 8'h7F, 8'h7F,
		8'h03, 8'h9F, 8'h0F, 8'h63, 8'h00};
	stw_top uut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
		.clk_en_in(clk_en_in), .sfr_addr_in(addr), .sfr_wr_in(wr),
		.sfr_rd_in(rd), .sfr_wdata_in(wdata),
		.watchdog_irq_enable_in(irq_en),
		.watchdog_event_clr_in(evt_clr), .sfr_rdata_out(rdata),
		.micro_tick_out(micro), .milli_tick_out(milli),
		.hundred_tick_out(hund), .slow_pending_out(slow_p),
		.fast_pending_out(fast_p), .watchdog_event_out(evt),
		.watchdog_irq_out(irq), .watchdog_irq_high_out(irq_hi),
		.watchdog_counting_out(cnt_on), .pulse_module_gate_out(pg),
		.converter_gate_out(cg), .serial_periph_gate_out(sg));
	stw_core_model core (.mclk_in(mclk_in), .sfr_rdata_in(rdata),
		.sfr_addr_out(addr), .sfr_wr_out(wr), .sfr_rd_out(rd),
		.sfr_wdata_out(wdata));
	initial begin
		mclk_in = 1'b0;
		forever #5 mclk_in = ~mclk_in;
	end
	// the ceiling is about twenty times the expected run length
	always @(posedge mclk_in) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			mismatches++;
			complete_run();
		end
	end
	task automatic complete_run();
		if (mismatches == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wait_hi(input int s, output int t);
		int n;
		n = 0;
		do begin
			@(posedge mclk_in);
			#1;
			n++;
		end while (mon[s] !== 1'b1 && n < 500);
		t = cyc;
	endtask
	task automatic period(input int s, input int exp);
		int t0;
		logic [7:0] d;
		if (s == 3) core.ack_fast(d);
		if (s == 4) core.rd_reg(8'hF9, d);
		wait_hi(s, t0);
		if (s == 3) core.ack_fast(d);
		if (s == 4) core.rd_reg(8'hF9, d);
		wait_hi(s, last_t);
		check(8'(last_t - t0), 8'(exp));
	endtask
	task automatic reg_test();
		logic [7:0] d;
		for (int i = 0; i < 10; i++) begin
			core.rd_reg(ra[i], d);
			check(d, rv[i]);
		end
		core.wr_reg(8'hFB, 8'hE2);
		core.wr_reg(8'hFC, 8'h09);
		core.wr_reg(8'hFD, 8'h00);
		core.wr_reg(8'hFE, 8'h02);
		core.wr_reg(8'hF1, 8'h10);
		core.wr_reg(8'hF0, 8'h5A);
		core.rd_reg(8'hFB, d);
		check(d, 8'h02);
		core.rd_reg(8'hF0, d);
		check(d, 8'h00);
		check({5'h0, pg, cg, sg}, 8'h04);
	endtask
	task automatic interval_test();
		logic [7:0] d;
		int t;
		period(0, 3);
		period(1, 10);
		period(2, 30);
		core.wr_reg(8'hFA, 8'h83);
		core.rd_reg(8'hFA, d);
		check(d, 8'h03);
		period(3, 40);
		core.ack_fast(d);
		core.wr_reg(8'hFA, 8'h01);
		wait_hi(3, t);
		check(8'(t - last_t), 8'd40);
		period(3, 20);
		core.wr_reg(8'hF9, 8'h81);
		core.rd_reg(8'hF9, d);
		check(d, 8'h01);
		period(4, 60);
	endtask
	task automatic clear_event();
		@(posedge mclk_in);
		evt_clr <= 1'b1;
		@(posedge mclk_in);
		evt_clr <= 1'b0;
		#1;
	endtask
	task automatic watchdog_test();
		int t0, t1;
		core.wr_reg(8'hF8, 8'h10);
		#1;
		check({7'h0, irq_hi}, 8'h01);
		irq_en <= 1'b1;
		core.pulse_bit(7, 5'h01);
		#1;
		check({7'h0, cnt_on}, 8'h01);
		clear_event();
		repeat (4) begin
			repeat (30) @(posedge mclk_in);
			core.pulse_bit(5, 5'h01);
		end
		#1;
		t0 = cyc;
		check({7'h0, evt}, 8'h00);
		wait_hi(5, t1);
		check({7'h0, t1 - t0 >= 60 && t1 - t0 <= 90}, 8'h01);
		@(posedge mclk_in);
		#1;
		check({7'h0, irq}, 8'h01);
		irq_en <= 1'b0;
		repeat (2) @(posedge mclk_in);
		#1;
		check({7'h0, irq}, 8'h00);
		core.pulse_bit(6, 5'h01);
		#1;
		check({7'h0, cnt_on}, 8'h00);
		clear_event();
		repeat (200) @(posedge mclk_in);
		#1;
		check({7'h0, evt}, 8'h00);
	endtask
	task automatic gate_test();
		logic seen;
		logic [7:0] d;
		seen = 1'b0;
		clk_en_in <= 1'b0;
		core.wr_reg(8'hFB, 8'h1A);
		clk_en_in <= 1'b1;
		core.rd_reg(8'hFB, d);
		check(d, 8'h02);
		core.wr_reg(8'hF1, 8'h1F);
		#1;
		check({5'h0, pg, cg, sg}, 8'h07);
		repeat (100) begin
			@(posedge mclk_in);
			#1;
			seen = seen | micro | milli | hund;
		end
		check({7'h0, seen}, 8'h00);
	endtask
	initial begin
		sys_rst_in = 1'b1;
		clk_en_in = 1'b1;
		irq_en = 1'b0;
		evt_clr = 1'b0;
		cyc = 0;
		mismatches = 0;
		check_count = 0;
		repeat (2) @(posedge mclk_in);
		sys_rst_in <= 1'b0;
		reg_test();
		interval_test();
		watchdog_test();
		gate_test();
		complete_run();
	end
endmodule
